// [rtl/mvw_pkg.sv]
/*
 * Shared constants and carrier types for the VLAN tag and wake filter block.
 * Assumes a 32-bit APB3 register bus and a byte-wide receive stream on the MAC clock.
 */
`default_nettype none
package mvw_pkg;
	// *****************************
	// register map (word indices, byte address = index * 4)
	// *****************************
	localparam logic [3:0] IDX_VLAN_TAG_ONE   = 4'h9;
	localparam logic [3:0] IDX_VLAN_TAG_TWO   = 4'hA;
	localparam logic [3:0] IDX_WAKE_FILTER    = 4'hB;
	localparam logic [3:0] IDX_WAKE_CTL_STAT  = 4'hC;
	localparam logic [3:0] IDX_IRQ_STATUS     = 4'hD;
	localparam logic [3:0] IDX_IRQ_MASK       = 4'hE;
	localparam logic [7:0] ADDR_VLAN_TAG_ONE  = {2'h0, IDX_VLAN_TAG_ONE, 2'h0};
	localparam logic [7:0] ADDR_VLAN_TAG_TWO  = {2'h0, IDX_VLAN_TAG_TWO, 2'h0};
	localparam logic [7:0] ADDR_WAKE_FILTER   = {2'h0, IDX_WAKE_FILTER, 2'h0};
	localparam logic [7:0] ADDR_WAKE_CTL_STAT = {2'h0, IDX_WAKE_CTL_STAT, 2'h0};
	localparam logic [7:0] ADDR_IRQ_STATUS    = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [7:0] ADDR_IRQ_MASK      = {2'h0, IDX_IRQ_MASK, 2'h0};
	localparam logic [31:0] RST_WORD          = 32'h0000_0000;
	// *****************************
	// field positions
	// *****************************
	localparam int GLOBAL_UNICAST_WAKE_ENABLE = 9;
	localparam int WAKE_FRAME_RECEIVED        = 6;
	localparam int WAKE_PACKET_RECEIVED       = 5;
	localparam int WAKE_FRAME_MODE_ENABLE     = 2;
	localparam int WAKE_PACKET_MODE_ENABLE    = 1;
	localparam logic [31:0] CTL_WRITABLE      = 32'h0000_0206;
	localparam int IRQ_WAKE_FRAME             = 0;
	localparam int IRQ_WAKE_PACKET            = 1;
	localparam int IRQ_UNICAST                = 2;
	localparam int FILT_ENABLE                = 31;
	// *****************************
	// frame figures
	// *****************************
	localparam logic [11:0] LEN_UNTAGGED      = 12'd1518;
	localparam logic [11:0] LEN_TAGGED        = 12'd1522;
	localparam logic [10:0] TAG_HI_INDEX      = 11'd12;
	localparam logic [10:0] TAG_LO_INDEX      = 11'd13;
	localparam logic [10:0] FILT_WINDOW       = 11'd32;
	localparam logic [2:0]  SYNC_RUN          = 3'd6;
	localparam logic [2:0]  ADDR_LAST         = 3'd5;
	localparam logic [4:0]  REPS_LAST         = 5'd15;
	localparam logic [7:0]  SYNC_BYTE         = 8'hFF;
	localparam int FILT_ENTRIES               = 8;
	localparam int FILT_COUNT                 = 4;
	// *****************************
	// carriers
	// *****************************
	typedef struct packed {
		logic       valid;
		logic       last;
		logic       err;
		logic [7:0] data;
	} mvw_rx_s;
	typedef struct packed {
		logic frame;
		logic packet;
		logic unicast;
	} mvw_wake_s;
endpackage
`default_nettype wire

// [rtl/mvw_top.sv]
/*
 * VLAN tag recognition, frame length check and remote wake detection with APB registers.
 * Assumes receive bytes, station address and power-save level come from logic on CLK.
 */
// Functional notes
// RULE1: a frame recognised as tagged is legal up to 1522 bytes instead of 1518.
// RULE2: the first tag identifier is compared with bytes thirteen and fourteen of each frame.
// RULE3: the second tag identifier is compared with bytes thirteen and fourteen of each frame.
// RULE4: software programs a used tag identifier to 0x8100; the upper sixteen tag bits are reserved.
// RULE5: any reset points the filter load pointer at entry zero.
// RULE6: each write to the filter port fills the next entry and advances the pointer by one.
// RULE7: after the eighth entry the pointer wraps to the first entry.
// RULE8: with global unicast wake enabled, a frame whose address bit 0 is zero ends power saving.
// RULE9: a matching wake frame sets wake frame received, bit 6.
// RULE10: a standard pattern wake packet sets wake packet received, bit 5.
// RULE11: while bit 2 is set, frames are checked against the wake frame filter.
// RULE12: while bit 1 is set, pattern wake packets are detected.
// RULE13: both wake status bits stay set until software clears them or reset.
`timescale 1ns/100ps
`default_nettype none
module mvw_top (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// receive stream, station address and power save
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_LAST,
	input  wire logic        RX_ERR,
	input  wire logic [47:0] STATION_ADDR,
	input  wire logic        PWR_SAVE,
	// results
	output logic             FRAME_DONE,
	output logic             FRAME_LEN_OK,
	output logic             FRAME_VLAN,
	output logic             WAKE,
	output logic             IRQ
);
	// *****************************
	// helpers
	// *****************************
	function automatic logic [7:0] addr_byte(input logic [47:0] addr, input logic [2:0] idx);
		addr_byte = addr[{idx, 3'b000} +: 8];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == mvw_pkg::ADDR_VLAN_TAG_ONE) || (a == mvw_pkg::ADDR_VLAN_TAG_TWO)
			|| (a == mvw_pkg::ADDR_WAKE_FILTER) || (a == mvw_pkg::ADDR_WAKE_CTL_STAT)
			|| (a == mvw_pkg::ADDR_IRQ_STATUS) || (a == mvw_pkg::ADDR_IRQ_MASK);
	endfunction

	mvw_pkg::mvw_rx_s rx;
	assign rx = '{valid: RX_VALID, last: RX_LAST, err: RX_ERR, data: RX_DATA};

	// *****************************
	// apb access
	// *****************************
	logic wr_acc;
	logic rd_acc;
	logic wr_filt;
	logic rd_irq;
	assign PREADY  = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
	assign wr_acc  = PREADY && PWRITE && mapped(PADDR);
	assign rd_acc  = PREADY && !PWRITE;
	assign wr_filt = wr_acc && (PADDR == mvw_pkg::ADDR_WAKE_FILTER);
	assign rd_irq  = rd_acc && (PADDR == mvw_pkg::ADDR_IRQ_STATUS);

	logic [15:0] tag_one_reg, tag_one_next, tag_two_reg, tag_two_next;
	logic [31:0] ctl_reg, ctl_next, prdata_reg, prdata_next;
	logic [2:0]  ptr_reg, ptr_next, irq_mask_reg, irq_mask_next, irq_st_reg, irq_st_next;
	logic [31:0] filt_reg [mvw_pkg::FILT_ENTRIES];
	logic        irq_reg, irq_next;
	mvw_pkg::mvw_wake_s wake_ev;

	always_comb begin
		tag_one_next  = tag_one_reg;
		tag_two_next  = tag_two_reg;
		ctl_next      = ctl_reg;
		irq_mask_next = irq_mask_reg;
		ptr_next      = ptr_reg;
		irq_st_next   = irq_st_reg;
		prdata_next   = prdata_reg;
		if (wr_acc && PADDR == mvw_pkg::ADDR_VLAN_TAG_ONE) begin
			tag_one_next = PWDATA[15:0];
		end else if (wr_acc && PADDR == mvw_pkg::ADDR_VLAN_TAG_TWO) begin
			tag_two_next = PWDATA[15:0];
		end else if (wr_filt) begin
			// 3-bit pointer: entry 7 rolls over to 0
			ptr_next = ptr_reg + 3'd1; // RULE6 RULE7
		end else if (wr_acc && PADDR == mvw_pkg::ADDR_WAKE_CTL_STAT) begin
			ctl_next = (PWDATA & mvw_pkg::CTL_WRITABLE) | (ctl_reg & ~mvw_pkg::CTL_WRITABLE);
			// write one clears a received flag
			ctl_next[mvw_pkg::WAKE_FRAME_RECEIVED]  = ctl_reg[mvw_pkg::WAKE_FRAME_RECEIVED]
				& ~PWDATA[mvw_pkg::WAKE_FRAME_RECEIVED]; // RULE13
			ctl_next[mvw_pkg::WAKE_PACKET_RECEIVED] = ctl_reg[mvw_pkg::WAKE_PACKET_RECEIVED]
				& ~PWDATA[mvw_pkg::WAKE_PACKET_RECEIVED]; // RULE13
		end else if (wr_acc && PADDR == mvw_pkg::ADDR_IRQ_MASK) begin
			irq_mask_next = PWDATA[2:0];
		end
		if (rd_irq) begin
			// clear only what the setup edge snapshot reported, so a later set survives
			irq_st_next = irq_st_reg & ~prdata_reg[2:0];
		end
		// hardware set wins over any clear in the same cycle
		if (wake_ev.frame) begin
			ctl_next[mvw_pkg::WAKE_FRAME_RECEIVED] = 1'b1; // RULE9
			irq_st_next[mvw_pkg::IRQ_WAKE_FRAME] = 1'b1;
		end
		if (wake_ev.packet) begin
			ctl_next[mvw_pkg::WAKE_PACKET_RECEIVED] = 1'b1; // RULE10
			irq_st_next[mvw_pkg::IRQ_WAKE_PACKET] = 1'b1;
		end
		if (wake_ev.unicast) begin
			irq_st_next[mvw_pkg::IRQ_UNICAST] = 1'b1;
		end
		irq_next = |(irq_st_next & irq_mask_next);
		// read data is sampled in the setup cycle so the answer needs no wait state
		if (PSEL && !PENABLE) begin
			if (PADDR == mvw_pkg::ADDR_VLAN_TAG_ONE) begin
				prdata_next = {16'h0000, tag_one_reg};
			end else if (PADDR == mvw_pkg::ADDR_VLAN_TAG_TWO) begin
				prdata_next = {16'h0000, tag_two_reg};
			end else if (PADDR == mvw_pkg::ADDR_WAKE_CTL_STAT) begin
				prdata_next = ctl_reg;
			end else if (PADDR == mvw_pkg::ADDR_IRQ_STATUS) begin
				prdata_next = {29'h0000_0000, irq_st_reg};
			end else if (PADDR == mvw_pkg::ADDR_IRQ_MASK) begin
				prdata_next = {29'h0000_0000, irq_mask_reg};
			end else begin
				prdata_next = mvw_pkg::RST_WORD;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tag_one_reg  <= 16'h0000;
			tag_two_reg  <= 16'h0000;
			ctl_reg      <= mvw_pkg::RST_WORD;
			ptr_reg      <= 3'h0; // RULE5
			irq_mask_reg <= 3'h0;
			irq_st_reg   <= 3'h0;
			irq_reg      <= 1'b0;
			prdata_reg   <= mvw_pkg::RST_WORD;
		end else begin
			tag_one_reg  <= tag_one_next;
			tag_two_reg  <= tag_two_next;
			ctl_reg      <= ctl_next;
			ptr_reg      <= ptr_next;
			irq_mask_reg <= irq_mask_next;
			irq_st_reg   <= irq_st_next;
			irq_reg      <= irq_next;
			prdata_reg   <= prdata_next;
		end
	end
	assign PRDATA = prdata_reg;
	assign IRQ    = irq_reg;

	// *****************************
	// wake filter store
	// *****************************
	genvar gi;
	generate
		for (gi = 0; gi < mvw_pkg::FILT_ENTRIES; gi++) begin : g_filt
			logic [31:0] word_next;
			always_comb begin
				word_next = filt_reg[gi];
				if (wr_filt && ptr_reg == 3'(gi)) begin
					word_next = PWDATA; // RULE6
				end
			end
			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					filt_reg[gi] <= mvw_pkg::RST_WORD;
				end else begin
					filt_reg[gi] <= word_next;
				end
			end
		end
	endgenerate

	// *****************************
	// frame tracking
	// *****************************
	logic [10:0] cnt_reg, cnt_next;
	logic [7:0]  tag_hi_reg, tag_hi_next;
	logic        vl1_reg, vl1_next, vl2_reg, vl2_next, mcast_reg, mcast_next;
	logic [2:0]  run_reg, run_next, idx_reg, idx_next;
	logic [4:0]  rep_reg, rep_next;
	logic        mp_on_reg, mp_on_next, mp_hit_reg, mp_hit_next;
	logic        done_reg, lenok_reg, vlan_reg, wake_reg;
	logic [11:0] frame_len;
	logic        vlan_now, end_ok, uni_now;
	logic [mvw_pkg::FILT_COUNT-1:0] filt_hit;

	assign frame_len = {1'b0, cnt_reg} + 12'd1;
	assign vlan_now  = vl1_reg || vl2_reg;
	assign uni_now   = (cnt_reg == 11'd0) ? !rx.data[0] : !mcast_reg;
	assign end_ok    = rx.valid && rx.last && !rx.err
		&& (frame_len <= (vlan_now ? mvw_pkg::LEN_TAGGED : mvw_pkg::LEN_UNTAGGED)); // RULE1

	always_comb begin
		cnt_next    = cnt_reg;
		tag_hi_next = tag_hi_reg;
		vl1_next    = vl1_reg;
		vl2_next    = vl2_reg;
		mcast_next  = mcast_reg;
		run_next    = run_reg;
		idx_next    = idx_reg;
		rep_next    = rep_reg;
		mp_on_next  = mp_on_reg;
		mp_hit_next = mp_hit_reg;
		if (rx.valid) begin
			if (cnt_reg != 11'h7FF) begin
				cnt_next = cnt_reg + 11'd1;
			end
			if (cnt_reg == 11'd0) begin
				mcast_next = rx.data[0];
			end
			if (cnt_reg == mvw_pkg::TAG_HI_INDEX) begin
				tag_hi_next = rx.data;
			end
			if (cnt_reg == mvw_pkg::TAG_LO_INDEX) begin
				vl1_next = ({tag_hi_reg, rx.data} == tag_one_reg); // RULE2
				vl2_next = ({tag_hi_reg, rx.data} == tag_two_reg); // RULE3
			end
			// sync run of six 0xFF, then the station address sixteen times
			if (mp_hit_reg) begin
				mp_on_next = 1'b0;
			end else if (mp_on_reg) begin
				if (rx.data == addr_byte(STATION_ADDR, idx_reg)) begin
					idx_next = (idx_reg == mvw_pkg::ADDR_LAST) ? 3'd0 : idx_reg + 3'd1;
					if (idx_reg == mvw_pkg::ADDR_LAST) begin
						rep_next = rep_reg + 5'd1;
						mp_hit_next = (rep_reg == mvw_pkg::REPS_LAST); // RULE12
					end
				end else begin
					mp_on_next = 1'b0;
					idx_next   = 3'd0;
					rep_next   = 5'd0;
					run_next   = (rx.data == mvw_pkg::SYNC_BYTE) ? 3'd1 : 3'd0;
				end
			end else if (run_reg == mvw_pkg::SYNC_RUN && rx.data == addr_byte(STATION_ADDR, 3'd0)) begin
				mp_on_next = 1'b1;
				idx_next   = 3'd1;
				rep_next   = 5'd0;
			end else if (rx.data == mvw_pkg::SYNC_BYTE) begin
				run_next = (run_reg == mvw_pkg::SYNC_RUN) ? run_reg : run_reg + 3'd1;
			end else begin
				run_next = 3'd0;
			end
			if (rx.last) begin
				cnt_next    = 11'd0;
				vl1_next    = 1'b0;
				vl2_next    = 1'b0;
				run_next    = 3'd0;
				idx_next    = 3'd0;
				rep_next    = 5'd0;
				mp_on_next  = 1'b0;
				mp_hit_next = 1'b0;
			end
		end
	end

	assign wake_ev.frame   = end_ok && ctl_reg[mvw_pkg::WAKE_FRAME_MODE_ENABLE] && |filt_hit; // RULE11
	// registered hit: the last byte clears the next value; a pattern ending on the final byte is not seen
	assign wake_ev.packet  = end_ok && ctl_reg[mvw_pkg::WAKE_PACKET_MODE_ENABLE] && mp_hit_reg; // RULE12
	assign wake_ev.unicast = end_ok && ctl_reg[mvw_pkg::GLOBAL_UNICAST_WAKE_ENABLE] && uni_now; // RULE8

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cnt_reg    <= 11'd0;
			tag_hi_reg <= 8'h00;
			vl1_reg    <= 1'b0;
			vl2_reg    <= 1'b0;
			mcast_reg  <= 1'b0;
			run_reg    <= 3'd0;
			idx_reg    <= 3'd0;
			rep_reg    <= 5'd0;
			mp_on_reg  <= 1'b0;
			mp_hit_reg <= 1'b0;
			done_reg   <= 1'b0;
			lenok_reg  <= 1'b0;
			vlan_reg   <= 1'b0;
			wake_reg   <= 1'b0;
		end else begin
			cnt_reg    <= cnt_next;
			tag_hi_reg <= tag_hi_next;
			vl1_reg    <= vl1_next;
			vl2_reg    <= vl2_next;
			mcast_reg  <= mcast_next;
			run_reg    <= run_next;
			idx_reg    <= idx_next;
			rep_reg    <= rep_next;
			mp_on_reg  <= mp_on_next;
			mp_hit_reg <= mp_hit_next;
			done_reg   <= rx.valid && rx.last;
			lenok_reg  <= end_ok;
			vlan_reg   <= rx.valid && rx.last && vlan_now;
			wake_reg   <= PWR_SAVE && (wake_ev.frame || wake_ev.packet || wake_ev.unicast); // RULE8
		end
	end
	assign FRAME_DONE   = done_reg;
	assign FRAME_LEN_OK = lenok_reg;
	assign FRAME_VLAN   = vlan_reg;
	assign WAKE         = wake_reg;

	// *****************************
	// filter match: entry i masks bytes 0..31, entry i+4 holds enable and xor signature
	// *****************************
	generate
		for (gi = 0; gi < mvw_pkg::FILT_COUNT; gi++) begin : g_match
			logic [7:0] acc_reg, acc_next, acc_upd;
			always_comb begin
				acc_upd = acc_reg;
				if (rx.valid && cnt_reg < mvw_pkg::FILT_WINDOW && filt_reg[gi][cnt_reg[4:0]]) begin
					acc_upd = acc_reg ^ rx.data;
				end
				acc_next = (rx.valid && rx.last) ? 8'h00 : acc_upd;
				filt_hit[gi] = filt_reg[gi + mvw_pkg::FILT_COUNT][mvw_pkg::FILT_ENABLE]
					&& (acc_upd == filt_reg[gi + mvw_pkg::FILT_COUNT][7:0]); // RULE11
			end
			always_ff @(posedge CLK) begin
				if (SYS_RST) begin
					acc_reg <= 8'h00;
				end else begin
					acc_reg <= acc_next;
				end
			end
		end
	endgenerate

	// *****************************
	// checks
	// *****************************
	sequence s_wrap;
		wr_filt && ptr_reg == 3'd7 ##1 ptr_reg == 3'd0;
	endsequence
	property p_len_tagged;
		@(posedge CLK) disable iff (SYS_RST)
		rx.valid && rx.last && !rx.err && vlan_now && frame_len == 12'd1522 |=> FRAME_LEN_OK;
	endproperty
	a_len_tagged: assert property (p_len_tagged) else $error("tagged 1522 byte frame refused"); // RULE1
	property p_len_plain;
		@(posedge CLK) disable iff (SYS_RST)
		rx.valid && rx.last && !vlan_now && frame_len == 12'd1519 |=> FRAME_DONE && !FRAME_LEN_OK;
	endproperty
	a_len_plain: assert property (p_len_plain) else $error("untagged 1519 byte frame accepted"); // RULE1
	property p_tag_one;
		@(posedge CLK) disable iff (SYS_RST)
		rx.valid && !rx.last && cnt_reg == 11'd13 && {tag_hi_reg, rx.data} == tag_one_reg |=> vl1_reg;
	endproperty
	a_tag_one: assert property (p_tag_one) else $error("first tag not detected"); // RULE2
	property p_tag_two;
		@(posedge CLK) disable iff (SYS_RST)
		rx.valid && !rx.last && cnt_reg == 11'd13 && {tag_hi_reg, rx.data} != tag_two_reg |=> !vl2_reg;
	endproperty
	a_tag_two: assert property (p_tag_two) else $error("second tag falsely detected"); // RULE3
	property p_ptr_reset;
		@(posedge CLK) SYS_RST |=> ptr_reg == 3'd0;
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not cleared by reset"); // RULE5
	property p_fill;
		@(posedge CLK) disable iff (SYS_RST)
		wr_filt |=> filt_reg[$past(ptr_reg)] == $past(PWDATA) && ptr_reg == $past(ptr_reg) + 3'd1;
	endproperty
	a_fill: assert property (p_fill) else $error("filter entry not stored in order"); // RULE6
	property p_wrap;
		@(posedge CLK) disable iff (SYS_RST) wr_filt && ptr_reg == 3'd7 |-> s_wrap;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // RULE7
	property p_unicast;
		@(posedge CLK) disable iff (SYS_RST)
		end_ok && PWR_SAVE && ctl_reg[9] && uni_now |=> WAKE;
	endproperty
	a_unicast: assert property (p_unicast) else $error("unicast wake missed"); // RULE8
	property p_frame_flag;
		@(posedge CLK) disable iff (SYS_RST)
		end_ok && ctl_reg[2] && |filt_hit |=> ctl_reg[6] ##1 irq_st_reg[0] || rd_irq || $past(rd_irq);
	endproperty
	a_frame_flag: assert property (p_frame_flag) else $error("wake frame flag not set"); // RULE9
	property p_packet_off;
		@(posedge CLK) disable iff (SYS_RST)
		!ctl_reg[1] && !ctl_reg[5] && !wr_acc |=> !ctl_reg[5];
	endproperty
	a_packet_off: assert property (p_packet_off) else $error("wake packet flag set while disabled"); // RULE10
	property p_packet_flag;
		@(posedge CLK) disable iff (SYS_RST)
		end_ok && ctl_reg[1] && mp_hit_reg |=> ctl_reg[5];
	endproperty
	a_packet_flag: assert property (p_packet_flag) else $error("wake packet flag not set"); // RULE10
	property p_sticky;
		@(posedge CLK) disable iff (SYS_RST)
		ctl_reg[6] && !(wr_acc && PADDR == mvw_pkg::ADDR_WAKE_CTL_STAT) |=> ctl_reg[6];
	endproperty
	a_sticky: assert property (p_sticky) else $error("wake frame flag lost"); // RULE13
endmodule
`default_nettype wire

// [sim/mvw_phy_model.sv]
/*
 * Receive-side partner: plays a stored frame into the MAC byte stream.
 * Assumes the bench fills frm and calls send right after a rising CLK edge.
 */
`timescale 1ns/100ps
`default_nettype none
module mvw_phy_model (
	// clock
	input  wire logic       CLK,
	// byte stream towards the mac
	output logic            RX_VALID,
	output logic      [7:0] RX_DATA,
	output logic            RX_LAST,
	output logic            RX_ERR
);
	logic [7:0] frm [0:1535];
	initial begin
		RX_VALID = 1'b0;
		RX_DATA  = 8'h00;
		RX_LAST  = 1'b0;
		RX_ERR   = 1'b0;
	end
	// ****
	// frame player
	// ****
	task automatic send(input int n, input logic e, input int gap);
		for (int i = 0; i < n; i++) begin
			RX_VALID <= 1'b1;
			RX_DATA  <= frm[i];
			RX_LAST  <= (i == n - 1);
			RX_ERR   <= e && (i == n - 1);
			@(posedge CLK);
			if (gap > 0 && i == 7) begin
				// slow link: idle lane carries junk, never the held byte
				RX_VALID <= 1'b0;
				RX_DATA  <= ~frm[i];
				repeat (gap) @(posedge CLK);
			end
		end
		RX_VALID <= 1'b0;
		RX_LAST  <= 1'b0;
		RX_ERR   <= 1'b0;
		RX_DATA  <= ~frm[n - 1];
	endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
/*
 * Self-checking bench for mvw_top: register rows, frame rows, wake and filter cases.
 * Assumes mvw_phy_model as the receive partner and a zero-wait APB slave.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} mvw_reg_row_s;
	typedef struct packed {
		logic [11:0] n;
		logic [15:0] tag;
		logic        err;
		logic        ok;
		logic        vlan;
	} mvw_frm_row_s;
	localparam logic [47:0] STA = 48'h0A0B_0C0D_0E10;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pwr_save = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_last;
	logic        rx_err;
	logic        f_done;
	logic        f_ok;
	logic        f_vlan;
	logic        wake;
	logic        irq;
	logic [31:0] rd;
	logic        re;
	logic [3:0]  got;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	mvw_top DUT (
		.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_ERR(rx_err),
		.STATION_ADDR(STA), .PWR_SAVE(pwr_save), .FRAME_DONE(f_done), .FRAME_LEN_OK(f_ok),
		.FRAME_VLAN(f_vlan), .WAKE(wake), .IRQ(irq)
	);
	mvw_phy_model PHY (
		.CLK(clk), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_ERR(rx_err)
	);

	always #4 clk = ~clk;
	// hang guard, well above the eighteen frames below
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ****
	// shared tasks
	// ****
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0000_0000);
		check(nm, rd, want);
	endtask
	task automatic fill(input int n);
		for (int i = 0; i < n; i++)
			PHY.frm[i] = 8'(i) ^ 8'h3C;
	endtask
	// flags are caught in the single cycle they stand, then done and wake must be gone
	task automatic frame(input int n, input logic e);
		PHY.send(n, e, 3);
		@(posedge clk);
		got = {f_done, f_ok, f_vlan, wake};
		@(posedge clk);
		check("pulse end", {f_done, wake}, 2'b00);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		mvw_reg_row_s rr [9];
		mvw_frm_row_s fr [7];
		rr = '{'{8'h24, 32'hFFFF_8100, 32'h0000_8100, 1'b0}, '{8'h28, 32'h1234_8100, 32'h0000_8100, 1'b0},
			'{8'h2C, 32'hA5A5_A5A5, 32'h0000_0000, 1'b0}, '{8'h30, 32'hFFFF_FFFF, 32'h0000_0206, 1'b0},
			'{8'h30, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{8'h38, 32'hFFFF_FFFF, 32'h0000_0007, 1'b0},
			'{8'h34, 32'h0000_0007, 32'h0000_0000, 1'b0}, '{8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
			'{8'h00, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
		fr = '{'{12'h5EE, 16'h3031, 1'b0, 1'b1, 1'b0}, '{12'h5EF, 16'h3031, 1'b0, 1'b0, 1'b0},
			'{12'h5F2, 16'h8100, 1'b0, 1'b1, 1'b1}, '{12'h5F3, 16'h8100, 1'b0, 1'b0, 1'b1},
			'{12'h5F2, 16'h9100, 1'b0, 1'b0, 1'b0}, '{12'h5F2, 16'h3031, 1'b0, 1'b0, 1'b0},
			'{12'h040, 16'h8100, 1'b1, 1'b0, 1'b1}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 6; k++)
			rdchk("reset value", 8'h24 + 8'(4 * k), 32'h0000_0000);
		check("irq after reset", irq, 1'b0);
		$display("reset test done");
		foreach (rr[i]) begin
			apb(1'b1, rr[i].a, rr[i].d);
			rdchk("register read", rr[i].a, rr[i].x);
			check("register slverr", re, rr[i].e);
		end
		$display("register rows done");
		fill(1536);
		foreach (fr[i]) begin
			PHY.frm[12] = fr[i].tag[15:8];
			PHY.frm[13] = fr[i].tag[7:0];
			frame(fr[i].n, fr[i].err);
			check("frame flags", got, {1'b1, fr[i].ok, fr[i].vlan, 1'b0});
		end
		// first tag unused, so only the second one can mark the frame
		apb(1'b1, 8'h24, 32'h0000_0000);
		frame(1522, 1'b0);
		check("second tag alone", got, 4'b1110);
		$display("frame rows done");
		pwr_save <= 1'b1;
		apb(1'b1, 8'h30, 32'h0000_0200);
		PHY.frm[0] = 8'h01;
		frame(64, 1'b0);
		check("multicast wake", got[0], 1'b0);
		PHY.frm[0] = 8'h00;
		frame(64, 1'b0);
		check("unicast wake", got[0], 1'b1);
		check("irq unicast", irq, 1'b1);
		rdchk("irq status", 8'h34, 32'h0000_0004);
		repeat (2) @(posedge clk);
		check("irq after read", irq, 1'b0);
		rdchk("irq status cleared", 8'h34, 32'h0000_0000);
		apb(1'b1, 8'h30, 32'h0000_0000);
		frame(64, 1'b0);
		check("unicast disabled", got[0], 1'b0);
		$display("unicast test done");
		fill(128);
		for (int j = 0; j < 102; j++)
			PHY.frm[20 + j] = (j < 6) ? 8'hFF : STA[8 * ((j - 6) % 6) +: 8];
		frame(128, 1'b0);
		rdchk("packet mode off", 8'h30, 32'h0000_0000);
		apb(1'b1, 8'h30, 32'h0000_0002);
		frame(128, 1'b1);
		rdchk("packet bad frame", 8'h30, 32'h0000_0002);
		frame(128, 1'b0);
		check("packet wake", got[0], 1'b1);
		fill(128);
		frame(128, 1'b0);
		rdchk("packet sticky", 8'h30, 32'h0000_0022);
		apb(1'b1, 8'h30, 32'h0000_0022);
		rdchk("packet cleared", 8'h30, 32'h0000_0002);
		$display("wake packet test done");
		for (int k = 0; k < 3; k++)
			apb(1'b1, 8'h2C, 32'hFFFF_FFFF);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// stale entry 4 first, then five more words must wrap onto entries 0..4
		for (int k = 0; k < 13; k++)
			apb(1'b1, 8'h2C, (k % 8 == 0) ? 32'h0000_0001 : (k == 4) ? 32'h8000_00A5 :
				(k == 12) ? 32'h8000_005A : 32'h0000_0000);
		fill(64);
		PHY.frm[0] = 8'h5A;
		frame(64, 1'b0);
		rdchk("filter mode off", 8'h30, 32'h0000_0000);
		apb(1'b1, 8'h30, 32'h0000_0004);
		apb(1'b1, 8'h38, 32'h0000_0001);
		PHY.frm[0] = 8'hA5;
		frame(64, 1'b0);
		rdchk("filter stale entry", 8'h30, 32'h0000_0004);
		PHY.frm[0] = 8'h5A;
		frame(64, 1'b0);
		check("filter wake", got[0], 1'b1);
		check("irq frame", irq, 1'b1);
		rdchk("filter match", 8'h30, 32'h0000_0044);
		rdchk("irq frame status", 8'h34, 32'h0000_0001);
		$display("wake filter test done");
		end_sim();
	end
endmodule
`default_nettype wire
